// ---- rtl/vrd_defs.vh ----
// Constants for the VXI reading data register port
//
// Overview of operation
// - Two transfer modes: real-time and post-measurement
// - Real-time read starts conversion, returns its result
// - Post-measurement read returns next stored reading
// - Readings passed in packed format, unchanged
// - Data register decoded in A24 window only
// - Device type reports 4096-byte A24 need
// - Offset register written by manager sets base
// - Config block at 1FC000 plus address times 64
// - Logical address defaults to 40
// - Data register at byte offset 12
// - Offset register holds base divided by 256
// - Offset register at byte offset 06
`ifndef VRD_DEFS_VH
`define VRD_DEFS_VH

// ============================================================
// Address modifiers (non-privileged and supervisory data)
`define VRD_AM_A16_USR 6'h29
`define VRD_AM_A16_SUP 6'h2D
`define VRD_AM_A24_USR 6'h39
`define VRD_AM_A24_SUP 6'h3D

// ============================================================
// Configuration block placement in A16
`define VRD_A16_CFG_BASE 24'h1FC000
`define VRD_A16_DEV_SHIFT 6
`define VRD_LA_RESET 8'h28

// ============================================================
// Configuration register byte offsets within the 64-byte block
`define VRD_CFG_ID_OFS 6'h00
`define VRD_CFG_TYPE_OFS 6'h02
`define VRD_CFG_STAT_OFS 6'h04
`define VRD_CFG_BASE_OFS 6'h06

// ============================================================
// Register contents and reset values
// ID value is arbitrary
`define VRD_ID_VALUE 16'h5A5A
// Memory code m, A24 size = 2^(23-m) bytes = 4096
`define VRD_TYPE_MEMREQ 4'hB
// Model code is arbitrary
`define VRD_TYPE_MODEL 12'h123
`define VRD_BASE_RESET 16'h0000
`define VRD_BASE_SHIFT 8

// ============================================================
// A24 window
`define VRD_A24_WIN_BYTES 4096
`define VRD_A24_WIN_BITS 12
`define VRD_A24_DATA_OFS 12'h00C

// ============================================================
// Reading path
`define VRD_DATA_W 16
`define VRD_FIFO_DEPTH 16
`define VRD_FIFO_AW 4

`endif

// ---- rtl/vrd_fifo.v ----
// Synchronous FIFO holding readings on their way to the bus
`timescale 1ns/10ps
module vrd_fifo #(
  parameter W = 16,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire flush_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [W-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [W-1:0] out_data_out
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  assign in_ready_out = (count_r != D[AW:0]);
  assign out_valid_out = (count_r != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr_r];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // ============================================================
  // Storage; no reset needed, the count guards stale words
  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end

  // ============================================================
  // Pointers and fill count; flush drops everything held
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else if (flush_in) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // vrd_fifo

// ---- rtl/vrd_top.v ----
// VXI slave port: A16 configuration block and A24 reading data register
`timescale 1ns/10ps
`include "vrd_defs.vh"
module vrd_top (
  input wire mclk_in,
  input wire arst_n_in,
  // VME bus pins, asynchronous to mclk_in
  input wire vme_as_n_in,
  input wire vme_ds_n_in,
  input wire vme_write_n_in,
  input wire [5:0] vme_am_in,
  input wire [23:0] vme_addr_in,
  input wire [15:0] vme_data_in,
  output reg [15:0] vme_data_out,
  output reg vme_data_oe_out,
  output reg vme_dtack_n_out,
  output reg vme_dtack_oe_out,
  // Local configuration, same clock
  input wire xfer_mode_post_in,
  input wire la_load_in,
  input wire [7:0] module_logical_address_in,
  // Converter
  output reg conv_start_out,
  input wire conv_done_in,
  input wire [15:0] conv_data_in,
  // Sample memory
  output reg mem_rd_out,
  input wire mem_valid_in,
  input wire [15:0] mem_data_in,
  // Status
  output reg [15:0] a24_base_out,
  output reg [7:0] logical_address_out
);
  localparam SW = 49;
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_ACK = 2'h2;
  localparam ST_REL = 2'h3;

  // ============================================================
  // Pin synchroniser: stage one feeds stage two only
  wire [SW-1:0] pins_raw;
  reg [SW-1:0] sync1_r;
  reg [SW-1:0] sync2_r;
  assign pins_raw = {vme_as_n_in, vme_ds_n_in, vme_write_n_in, vme_am_in,
    vme_addr_in, vme_data_in};
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_r <= {SW{1'b1}};
      sync2_r <= {SW{1'b1}};
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
    end
  end

  wire as_act;
  wire ds_act;
  wire wr_act;
  wire [5:0] am_s;
  wire [23:0] addr_s;
  wire [15:0] wdata_s;
  assign as_act = ~sync2_r[48];
  assign ds_act = ~sync2_r[47];
  assign wr_act = ~sync2_r[46];
  assign am_s = sync2_r[45:40];
  assign addr_s = sync2_r[39:16];
  assign wdata_s = sync2_r[15:0];

  // ============================================================
  // Address decode
  reg [7:0] la_r;
  reg [15:0] base_r;
  reg mode_post_r;
  wire [23:0] cfg_base;
  wire [23:0] a24_base;
  wire am_a16;
  wire am_a24;
  wire hit_a16;
  wire hit_a24;
  wire hit_data;
  wire [5:0] cfg_ofs;

  // A16 carries only the low 16 address bits of the block base
  assign cfg_base = `VRD_A16_CFG_BASE +
    ({16'h0000, la_r} << `VRD_A16_DEV_SHIFT);
  assign a24_base = {base_r, 8'h00};
  assign am_a16 = (am_s == `VRD_AM_A16_USR) || (am_s == `VRD_AM_A16_SUP);
  assign am_a24 = (am_s == `VRD_AM_A24_USR) || (am_s == `VRD_AM_A24_SUP);
  assign hit_a16 = am_a16 &&
    (addr_s[15:`VRD_A16_DEV_SHIFT] ==
     cfg_base[15:`VRD_A16_DEV_SHIFT]);
  // Window compare on the upper bits: 4096-byte aligned block
  assign hit_a24 = am_a24 &&
    (addr_s[23:`VRD_A24_WIN_BITS] ==
     a24_base[23:`VRD_A24_WIN_BITS]);
  assign hit_data = hit_a24 &&
    (addr_s[`VRD_A24_WIN_BITS-1:0] == `VRD_A24_DATA_OFS);
  assign cfg_ofs = addr_s[5:0];

  // ============================================================
  // Configuration register read mux
  reg [15:0] cfg_rdata;
  always @* begin
    case (cfg_ofs)
      `VRD_CFG_ID_OFS: cfg_rdata = `VRD_ID_VALUE;
      `VRD_CFG_TYPE_OFS: cfg_rdata = {`VRD_TYPE_MEMREQ,
        `VRD_TYPE_MODEL};
      `VRD_CFG_STAT_OFS: cfg_rdata = {15'h0000, mode_post_r};
      `VRD_CFG_BASE_OFS: cfg_rdata = base_r;
      default: cfg_rdata = 16'h0000;
    endcase
  end

  // ============================================================
  // Reading FIFO between converter or memory and the bus
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out_data;
  reg fifo_in_valid;
  reg [15:0] fifo_in_data;
  reg fifo_pop;
  reg fifo_flush;
  reg mem_pend_r;

  // Source follows the mode; data goes in untouched
  always @* begin
    if (mode_post_r) begin
      fifo_in_valid = mem_valid_in;
      fifo_in_data = mem_data_in;
    end else begin
      fifo_in_valid = conv_done_in;
      fifo_in_data = conv_data_in;
    end
  end

  vrd_fifo #(
    .W(`VRD_DATA_W),
    .D(`VRD_FIFO_DEPTH),
    .AW(`VRD_FIFO_AW)
  ) u_fifo (
    .clk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .flush_in(fifo_flush),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out_data)
  );

  // ============================================================
  // Mode register; a mode change flushes readings of the old mode
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_post_r <= 1'b0;
      fifo_flush <= 1'b0;
    end else begin
      mode_post_r <= xfer_mode_post_in;
      fifo_flush <= (mode_post_r != xfer_mode_post_in);
    end
  end

  // ============================================================
  // Logical address: shipped value until reloaded
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      la_r <= `VRD_LA_RESET;
    end else if (la_load_in) begin
      la_r <= module_logical_address_in;
    end
  end

  // ============================================================
  // Memory prefetch in post mode; stalls when the FIFO is full
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mem_rd_out <= 1'b0;
      mem_pend_r <= 1'b0;
    end else begin
      mem_rd_out <= 1'b0;
      if (!mode_post_r || fifo_flush) begin
        mem_pend_r <= 1'b0;
      end else if (mem_pend_r) begin
        if (mem_valid_in) begin
          mem_pend_r <= 1'b0;
        end
      end else if (fifo_in_ready && !mem_rd_out) begin
        mem_rd_out <= 1'b1;
        mem_pend_r <= 1'b1;
      end
    end
  end

  // ============================================================
  // Bus cycle sequencer
  reg [1:0] state_r;
  reg [1:0] state_nxt;

  always @* begin
    fifo_pop = 1'b0;
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (as_act && ds_act) begin
          if (hit_a16 || (hit_a24 && !hit_data) ||
              (hit_data && wr_act)) begin
            state_nxt = ST_ACK;
          end else if (hit_data) begin
            state_nxt = ST_WAIT;
          end else begin
            state_nxt = ST_REL;
          end
        end
      end
      ST_WAIT: begin
        if (!as_act) begin
          state_nxt = ST_IDLE;
        end else if (fifo_out_valid) begin
          fifo_pop = 1'b1;
          state_nxt = ST_ACK;
        end
      end
      ST_ACK: begin
        if (!ds_act) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_REL: begin
        if (!ds_act) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ============================================================
  // Bus side registers and outputs
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= ST_IDLE;
      base_r <= `VRD_BASE_RESET;
      vme_data_out <= 16'h0000;
      vme_data_oe_out <= 1'b0;
      vme_dtack_n_out <= 1'b1;
      vme_dtack_oe_out <= 1'b0;
      conv_start_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      conv_start_out <= 1'b0;
      if (state_r == ST_IDLE && state_nxt == ST_ACK) begin
        vme_dtack_n_out <= 1'b0;
        vme_dtack_oe_out <= 1'b1;
        if (hit_a16 && wr_act && cfg_ofs == `VRD_CFG_BASE_OFS) begin
          base_r <= wdata_s;
        end
        if (!wr_act) begin
          vme_data_out <= hit_a16 ? cfg_rdata : 16'h0000;
          vme_data_oe_out <= 1'b1;
        end
      end
      // Real-time read: one conversion per data register read
      if (state_r == ST_IDLE && state_nxt == ST_WAIT &&
          !mode_post_r) begin
        conv_start_out <= 1'b1;
      end
      if (fifo_pop) begin
        vme_data_out <= fifo_out_data;
        vme_data_oe_out <= 1'b1;
        vme_dtack_n_out <= 1'b0;
        vme_dtack_oe_out <= 1'b1;
      end
      // Release drivers once the master lifts its strobe
      if (state_nxt == ST_IDLE) begin
        vme_data_oe_out <= 1'b0;
        vme_dtack_n_out <= 1'b1;
        vme_dtack_oe_out <= 1'b0;
      end
    end
  end

  // ============================================================
  // Status copies
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      a24_base_out <= `VRD_BASE_RESET;
      logical_address_out <= `VRD_LA_RESET;
    end else begin
      a24_base_out <= base_r;
      logical_address_out <= la_r;
    end
  end
endmodule // vrd_top

// ---- tb/vrd_top_assertions.sv ----
// Port assertions for the reading data register port
`timescale 1ns/10ps
module vrd_top_assertions (
  input wire mclk_in,
  input wire arst_n_in,
  input wire vme_as_n_in,
  input wire vme_ds_n_in,
  input wire vme_write_n_in,
  input wire vme_data_oe_out,
  input wire vme_dtack_n_out,
  input wire vme_dtack_oe_out,
  input wire xfer_mode_post_in,
  input wire la_load_in,
  input wire [7:0] module_logical_address_in,
  input wire conv_start_out,
  input wire mem_rd_out,
  input wire [15:0] a24_base_out,
  input wire [7:0] logical_address_out
);
  // ==========================================
  // Handshake; pins reach the logic two edges late
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_ds_gone;
    vme_ds_n_in [*4];
  endsequence
  a_ack_release: assert property (s_ds_gone |-> !vme_dtack_oe_out)
    else $error("acknowledge outlives the data strobe");
  a_ack_strobe: assert property (vme_dtack_oe_out |->
    !$past(vme_ds_n_in, 3) && !$past(vme_as_n_in, 3))
    else $error("acknowledge without strobes");
  a_ack_low: assert property (vme_dtack_oe_out |-> !vme_dtack_n_out)
    else $error("acknowledge driven high");
  a_data_read: assert property (vme_data_oe_out |->
    vme_write_n_in && vme_dtack_oe_out)
    else $error("read data outside an acknowledged read");
  // ==========================================
  // Reading sources follow the transfer mode
  a_rt_only: assert property (conv_start_out |->
    !$past(xfer_mode_post_in, 2))
    else $error("conversion started in post mode");
  a_post_only: assert property (mem_rd_out |->
    $past(xfer_mode_post_in, 2))
    else $error("memory fetch in real-time mode");
  a_conv_pulse: assert property (conv_start_out |=> !conv_start_out)
    else $error("conversion start longer than one cycle");
  // ==========================================
  // Base and address registers
  a_base_load: assert property ($changed(a24_base_out) |->
    $past(vme_dtack_oe_out))
    else $error("base changed without a bus write");
  a_la_load: assert property (la_load_in |-> ##[1:2]
    logical_address_out == module_logical_address_in)
    else $error("logical address not loaded");
endmodule // vrd_top_assertions

bind vrd_top vrd_top_assertions u_vrd_top_assertions (
  .mclk_in(mclk_in), .arst_n_in(arst_n_in), .vme_as_n_in(vme_as_n_in),
  .vme_ds_n_in(vme_ds_n_in), .vme_write_n_in(vme_write_n_in),
  .vme_data_oe_out(vme_data_oe_out), .vme_dtack_n_out(vme_dtack_n_out),
  .vme_dtack_oe_out(vme_dtack_oe_out),
  .xfer_mode_post_in(xfer_mode_post_in), .la_load_in(la_load_in),
  .module_logical_address_in(module_logical_address_in),
  .conv_start_out(conv_start_out), .mem_rd_out(mem_rd_out),
  .a24_base_out(a24_base_out), .logical_address_out(logical_address_out));

// ---- tb/vrd_src_model.sv ----
// Converter and sample memory stand-in feeding the port
`timescale 1ns/10ps
module vrd_src_model (
  input wire clk_in,
  input wire slow_in,
  input wire conv_start_in,
  output reg conv_done_out = 1'b0,
  output wire [15:0] conv_data_out,
  input wire mem_rd_in,
  output reg mem_valid_out = 1'b0,
  output wire [15:0] mem_data_out
);
  reg [3:0] cw_r = 4'h0;
  reg [3:0] mw_r = 4'h0;
  reg [11:0] cn_r = 12'h000;
  reg [11:0] mn_r = 12'h000;
  reg [15:0] cd_r = 16'h0000;
  reg [15:0] md_r = 16'h0000;
  // Lines show the inverse when idle, so a stale word cannot pass
  assign conv_data_out = conv_done_out ? cd_r : ~cd_r;
  assign mem_data_out = mem_valid_out ? md_r : ~md_r;
  // ==========================================
  // One answer per request after 1 or 6 cycles; words are numbered
  always @(posedge clk_in) begin
    conv_done_out <= 1'b0;
    mem_valid_out <= 1'b0;
    if (conv_start_in) cw_r <= slow_in ? 4'h6 : 4'h1;
    else if (cw_r != 4'h0) cw_r <= cw_r - 4'h1;
    if (mem_rd_in) mw_r <= slow_in ? 4'h6 : 4'h1;
    else if (mw_r != 4'h0) mw_r <= mw_r - 4'h1;
    if (cw_r == 4'h1) begin
      conv_done_out <= 1'b1;
      cd_r <= {4'hC, cn_r};
      cn_r <= cn_r + 12'h001;
    end
    if (mw_r == 4'h1) begin
      mem_valid_out <= 1'b1;
      md_r <= {4'hA, mn_r};
      mn_r <= mn_r + 12'h001;
    end
  end
endmodule // vrd_src_model

// ---- tb/tb_vrd_top.sv ----
// Self-checking bench for the reading data register port
`timescale 1ns/10ps
`include "vrd_defs.vh"
module tb_vrd_top;
  reg mclk_in = 1'b0;
  reg arst_n_in = 1'b0;
  reg as_n = 1'b1, ds_n = 1'b1, wr_n = 1'b1, post = 1'b0;
  reg la_ld = 1'b0, slow = 1'b0;
  reg [5:0] am = 6'h00;
  reg [23:0] addr = 24'h000000;
  reg [15:0] wd = 16'h0000;
  reg [7:0] la = 8'h28;
  reg [11:0] k;
  wire [15:0] rd, base, cdat, mdat;
  wire doe, dk_n, dk_oe, cst, cdn, mrd, mvl;
  wire [7:0] la_out;
  integer fail_count = 0, checks = 0, cyc = 0;
  vrd_top u_vrd_top (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .vme_as_n_in(as_n), .vme_ds_n_in(ds_n), .vme_write_n_in(wr_n),
    .vme_am_in(am), .vme_addr_in(addr), .vme_data_in(wd),
    .vme_data_out(rd), .vme_data_oe_out(doe), .vme_dtack_n_out(dk_n),
    .vme_dtack_oe_out(dk_oe), .xfer_mode_post_in(post),
    .la_load_in(la_ld), .module_logical_address_in(la),
    .conv_start_out(cst), .conv_done_in(cdn), .conv_data_in(cdat),
    .mem_rd_out(mrd), .mem_valid_in(mvl), .mem_data_in(mdat),
    .a24_base_out(base), .logical_address_out(la_out));
  vrd_src_model u_vrd_src_model (.clk_in(mclk_in), .slow_in(slow),
    .conv_start_in(cst), .conv_done_out(cdn), .conv_data_out(cdat),
    .mem_rd_in(mrd), .mem_valid_out(mvl), .mem_data_out(mdat));
  // ==========================================
  // Clock and hang guard
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      summarize;
    end
  end
  task cmp16(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // One D16 cycle; strobes held until the acknowledge is seen
  task bus(input [5:0] m, input [23:0] a, input w, input [15:0] d,
    input ack, input [15:0] exp);
    integer n;
    begin
      @(posedge mclk_in);
      #10;
      am = m;
      addr = a;
      wr_n = !w;
      wd = d;
      as_n = 1'b0;
      ds_n = 1'b0;
      n = 0;
      while (dk_oe !== 1'b1 && n < 40) begin
        @(posedge mclk_in);
        #10;
        n = n + 1;
      end
      cmp16({15'h0000, dk_oe}, {15'h0000, ack});
      if (ack && !w) cmp16(rd, exp);
      as_n = 1'b1;
      ds_n = 1'b1;
      // Leave off the edge so the caller's next change cannot race it
      repeat (4) @(posedge mclk_in);
      #10;
    end
  endtask
  // ==========================================
  // Scenarios
  task t_cfg;
    begin
      cmp16({8'h00, la_out}, 16'h0028);
      cmp16(base, 16'h0000);
      bus(6'h29, 24'h00CA02, 0, 0, 1, 16'hB123);
      bus(6'h29, 24'h00CA00, 0, 0, 1, `VRD_ID_VALUE);
      bus(6'h29, 24'h00CA04, 0, 0, 1, 16'h0000);
      // Base 0x220000 is held as 0x2200, the address over 256
      bus(6'h2D, 24'h00CA06, 1, 16'h2200, 1, 0);
      cmp16(base, 16'h2200);
      bus(6'h29, 24'h00CA06, 0, 0, 1, 16'h2200);
      bus(6'h29, 24'h00CA46, 0, 0, 0, 0);
    end
  endtask
  task t_win;
    begin
      bus(6'h39, 24'h220000, 0, 0, 1, 16'h0000);
      bus(6'h39, 24'h220FFE, 0, 0, 1, 16'h0000);
      bus(6'h39, 24'h221000, 0, 0, 0, 0);
      bus(6'h3D, 24'h21FFFC, 0, 0, 0, 0);
      bus(6'h29, 24'h00000C, 0, 0, 0, 0);
    end
  endtask
  // Live reads, prompt then slow converter, back to back
  task t_rt;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        slow = k[1];
        bus(6'h3D, 24'h22000C, 0, 0, 1, {4'hC, k});
      end
    end
  endtask
  // Memory reads after a 60-cycle wait, 14 of 16 words buffered; slow source for the last 11, buffer never empties
  task t_post;
    begin
      slow = 1'b0;
      post = 1'b1;
      repeat (60) @(posedge mclk_in);
      #10;
      for (k = 0; k < 20; k = k + 1) begin
        slow = (k > 8);
        bus(6'h39, 24'h22000C, 0, 0, 1, {4'hA, k});
      end
      bus(6'h29, 24'h00CA04, 0, 0, 1, 16'h0001);
      post = 1'b0;
    end
  endtask
  task t_la;
    begin
      la = 8'h29;
      la_ld = 1'b1;
      @(posedge mclk_in);
      #10;
      la_ld = 1'b0;
      repeat (2) @(posedge mclk_in);
      #10;
      cmp16({8'h00, la_out}, 16'h0029);
      bus(6'h29, 24'h00CA46, 0, 0, 1, 16'h2200);
      bus(6'h29, 24'h00CA06, 0, 0, 0, 0);
    end
  endtask
  task summarize;
    begin
      if (fail_count == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk_in);
    #10;
    arst_n_in = 1'b1;
    t_cfg;
    t_win;
    t_rt;
    t_post;
    t_la;
    summarize;
  end
endmodule // tb_vrd_top
